// *** ucp_command_port.sv ***
// Command interpreter of the peripheral controller's 16-bit processor port.
// Assumes the USB engine drives its flags on clk and the port pins are asynchronous.
// Summary of operation
// - Codes F2 and F3 write and read the two-byte DMA byte count.
// - Written count sets DMA length; read returns bytes still remaining.
// - Byte count clears on hardware reset, survives a USB bus reset.
// - Internal down-counter reloads from the byte count without processor help.
// - With count-done enabled, counter reaching zero raises end of transfer.
// - Code F6 resets the controller like the hardware reset input.
// - Codes 01 to 0F write control IN and endpoints 1 to 14.
// - Code 10 reads control OUT; codes 12 to 1F read endpoints 1-14.
// - Buffer command rewinds pointer; each data access advances two bytes.
// - Buffer size up to 1023 isochronous, 32 bulk or interrupt.
// - Word 0 is packet length; later words hold two bytes, low first.
// - Select high carries code on D7-D0; select low carries 16-bit data.
// - DMA skips the length word; DMA reads mark the last word.
// - Bulk IN buffer is sent when full, or on external end of transfer.
// - No boundary checks; double-buffered DMA continues into secondary buffer.
// - Codes 50 to 5F read one endpoint status byte.
// - Reading status clears that endpoint's interrupt pending bit.
// - Status byte layout: stall, full1, full0, toggle, replaced, setup, buffer.
// - Stall set by stall, cleared by unstall or a set-up token.
// - Replaced flag set by overwriting set-up; status read clears it after.
`timescale 1ns/100ps
module ucp_command_port
    import ucp_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic usbBusReset,
    input wire ucp_pins_t portPins,
    output logic [15:0] portDataOut,
    output logic portDataOeN,
    input wire logic dmaEnable,
    input wire logic dmaToDevice,
    input wire logic countDoneEnable,
    input wire logic [3:0] dmaEndpoint,
    input wire logic dmaDoubleBuf,
    input wire logic endOfTransferPin,
    input wire logic dmaWrValid,
    output logic dmaWrReady,
    input wire logic [15:0] dmaWrData,
    output logic dmaRdValid,
    input wire logic dmaRdReady,
    output logic [15:0] dmaRdData,
    output logic endOfPacketMark,
    output logic endOfTransfer,
    output logic txCommit,
    output logic [3:0] txCommitEp,
    input wire logic [15:0] engFull0,
    input wire logic [15:0] engFull1,
    input wire logic [15:0] engToggle,
    input wire logic [15:0] engSetupPresent,
    input wire logic [15:0] engCpuBuf,
    input wire logic [15:0] setupTokenIn,
    input wire logic [15:0] setupReplacedIn,
    input wire logic [15:0] setupWriteBusy,
    input wire logic [15:0] epEventIn,
    output logic [15:0] deviceIrqFlags,
    output ucp_ep_status_t [15:0] epStatus
);

    // ------------------------------------------------------------------
    // Pin synchronisers and strobe edges
    // ------------------------------------------------------------------
    ucp_pins_t pinMeta_ff;
    ucp_pins_t pinSync_ff;
    ucp_pins_t pinLast_ff;
    logic eotMeta_ff;
    logic eotSync_ff;
    logic wrDone;
    logic rdDone;
    logic rdActive;
    logic softRst_ff;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pinMeta_ff <= PINS_IDLE;
            pinSync_ff <= PINS_IDLE;
            pinLast_ff <= PINS_IDLE;
            eotMeta_ff <= 1'b0;
            eotSync_ff <= 1'b0;
        end else begin
            pinMeta_ff <= portPins;
            pinSync_ff <= pinMeta_ff;
            pinLast_ff <= pinSync_ff;
            eotMeta_ff <= endOfTransferPin;
            eotSync_ff <= eotMeta_ff;
        end
    end

    // A strobe is taken at its rising (trailing) edge while chip select is low.
    assign wrDone = pinSync_ff.wrN && !pinLast_ff.wrN && !pinSync_ff.csN;
    assign rdDone = pinSync_ff.rdN && !pinLast_ff.rdN && !pinSync_ff.csN;
    assign rdActive = !pinSync_ff.rdN && !pinSync_ff.csN;

    // ------------------------------------------------------------------
    // Command decode
    // ------------------------------------------------------------------
    ucp_cmd_t cmd_ff;
    ucp_cmd_t nxt_cmd;
    logic [3:0] cmdEp_ff;
    logic [4:0] cpuPtr_ff;
    logic cmdTake;
    logic dataWr;
    logic dataRd;
    logic softRstCmd;
    logic [15:0] stallSet;
    logic [15:0] stallClr;
    logic [7:0] code;
    logic [3:0] codeHi;
    logic [3:0] codeEp;

    assign cmdTake = wrDone && pinSync_ff.cmdSel;
    assign dataWr = wrDone && !pinSync_ff.cmdSel;
    assign dataRd = rdDone && !pinSync_ff.cmdSel;
    assign code = pinSync_ff.data[7:0];
    assign codeHi = code[7:4];
    assign codeEp = code[3:0];

    always_comb begin
        nxt_cmd = CMD_NONE;
        softRstCmd = 1'b0;
        stallSet = '0;
        stallClr = '0;
        if (code == CMD_COUNT_WR) begin
            nxt_cmd = CMD_CNT_WR;
        end else if (code == CMD_COUNT_RD) begin
            nxt_cmd = CMD_CNT_RD;
        end else if (code == CMD_SOFT_RESET) begin
            softRstCmd = 1'b1;
        end else if (codeHi == GRP_BUF_WR && codeEp != EP_NONE_WR) begin
            nxt_cmd = CMD_BUF_WR;
        end else if (codeHi == GRP_BUF_RD && codeEp != EP_NONE_RD) begin
            nxt_cmd = CMD_BUF_RD;
        end else if (codeHi == GRP_STATUS) begin
            nxt_cmd = CMD_STAT_RD;
        end else if (codeHi == GRP_STALL) begin
            stallSet[codeEp] = 1'b1;
        end else if (codeHi == GRP_UNSTALL) begin
            stallClr[codeEp] = 1'b1;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            softRst_ff <= 1'b0;
        end else begin
            softRst_ff <= cmdTake && softRstCmd;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cmd_ff <= CMD_NONE;
            cmdEp_ff <= 4'h0;
            cpuPtr_ff <= PTR_START;
        end else if (softRst_ff) begin
            cmd_ff <= CMD_NONE;
            cmdEp_ff <= 4'h0;
            cpuPtr_ff <= PTR_START;
        end else if (cmdTake) begin
            cmd_ff <= nxt_cmd;
            cmdEp_ff <= codeEp;
            cpuPtr_ff <= PTR_START;
        end else if ((dataWr && cmd_ff == CMD_BUF_WR) || (dataRd && cmd_ff == CMD_BUF_RD)) begin
            cpuPtr_ff <= cpuPtr_ff + 5'h01;
        end
    end

    // ------------------------------------------------------------------
    // Endpoint buffer memory
    // ------------------------------------------------------------------
    logic [15:0] bufMem [0:MEM_WORDS-1];
    logic cpuMemWr;
    logic [9:0] cpuIdx;
    logic [9:0] cpuNxtIdx;
    logic [9:0] dmaIdx;
    logic [9:0] dmaNxtIdx;
    logic [9:0] dmaLenIdx;
    logic drainPop;
    logic fifoValid;
    logic [15:0] fifoData;
    logic [4:0] dmaPtr_ff;
    logic [4:0] nxt_dmaPtr;
    logic dmaBuf_ff;
    logic nxt_dmaBuf;
    logic [4:0] nxt_cpuPtr;

    // Word 0 holds the packet length; data words follow, low byte first.
    assign cpuMemWr = dataWr && cmd_ff == CMD_BUF_WR;
    assign cpuIdx = {cmdEp_ff, epStatus[cmdEp_ff].host_side_buf_select, cpuPtr_ff};
    assign nxt_cpuPtr = cmdTake ? PTR_START : (rdDone ? cpuPtr_ff + 5'h01 : cpuPtr_ff);
    assign cpuNxtIdx = {cmdEp_ff, epStatus[cmdEp_ff].host_side_buf_select, nxt_cpuPtr};
    assign dmaIdx = {dmaEndpoint, dmaBuf_ff, dmaPtr_ff};
    assign dmaNxtIdx = {dmaEndpoint, nxt_dmaBuf, nxt_dmaPtr};
    assign dmaLenIdx = {dmaEndpoint, dmaBuf_ff, PTR_START};

    always_ff @(posedge clk) begin
        if (cpuMemWr) begin
            bufMem[cpuIdx] <= pinSync_ff.data;
        end else if (drainPop) begin
            bufMem[dmaIdx] <= fifoData;
        end
    end

    // ------------------------------------------------------------------
    // Byte count register and DMA down-counter
    // ------------------------------------------------------------------
    ucp_dma_t dmaState_ff;
    logic [15:0] byteCount_ff;
    logic [15:0] remain_ff;
    logic [15:0] step;
    logic wordMoved;
    logic lastRdWord;
    logic bufEnd;
    logic extEot;
    logic countZero;
    logic dmaStop;

    assign step = (remain_ff >= BYTES_PER_WORD) ? BYTES_PER_WORD : remain_ff;
    assign wordMoved = drainPop || (dmaRdValid && dmaRdReady);
    assign countZero = wordMoved && (remain_ff == step);
    assign extEot = eotSync_ff && dmaState_ff == DMA_RUN;
    assign lastRdWord = {10'h000, dmaPtr_ff, 1'b0} >= bufMem[dmaLenIdx];
    assign bufEnd = wordMoved && dmaPtr_ff == BUF_LAST_WORD;
    assign dmaStop = !dmaEnable || extEot || countZero;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            byteCount_ff <= COUNT_RESET;
        end else if (softRst_ff) begin
            byteCount_ff <= COUNT_RESET;
        end else if (dataWr && cmd_ff == CMD_CNT_WR) begin
            byteCount_ff <= pinSync_ff.data;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            remain_ff <= COUNT_RESET;
        end else if (softRst_ff) begin
            remain_ff <= COUNT_RESET;
        end else if (dmaState_ff == DMA_IDLE) begin
            remain_ff <= byteCount_ff;
        end else if (wordMoved) begin
            remain_ff <= remain_ff - step;
        end
    end

    // ------------------------------------------------------------------
    // DMA sequencer
    // ------------------------------------------------------------------
    always_comb begin
        nxt_dmaPtr = dmaPtr_ff;
        nxt_dmaBuf = dmaBuf_ff;
        if (dmaState_ff == DMA_IDLE) begin
            nxt_dmaPtr = DMA_PTR_START;
            nxt_dmaBuf = epStatus[dmaEndpoint].host_side_buf_select;
        end else if (bufEnd && dmaDoubleBuf && !dmaBuf_ff) begin
            nxt_dmaPtr = DMA_PTR_START;
            nxt_dmaBuf = 1'b1;
        end else if (wordMoved) begin
            nxt_dmaPtr = dmaPtr_ff + 5'h01;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            dmaState_ff <= DMA_IDLE;
            dmaPtr_ff <= DMA_PTR_START;
            dmaBuf_ff <= 1'b0;
        end else if (softRst_ff || usbBusReset) begin
            dmaState_ff <= DMA_IDLE;
            dmaPtr_ff <= DMA_PTR_START;
            dmaBuf_ff <= 1'b0;
        end else begin
            dmaPtr_ff <= nxt_dmaPtr;
            dmaBuf_ff <= nxt_dmaBuf;
            if (dmaState_ff == DMA_IDLE) begin
                if (dmaEnable && byteCount_ff != COUNT_RESET) begin
                    dmaState_ff <= DMA_RUN;
                end
            end else if (dmaStop || (dmaRdValid && dmaRdReady && lastRdWord)) begin
                dmaState_ff <= DMA_IDLE;
            end
        end
    end

    ucp_fifo #(
        .WIDTH(DATA_W),
        .DEPTH(FIFO_DEPTH)
    ) u_wr_fifo (
        .clk(clk),
        .rst(rst),
        .clr(softRst_ff),
        .inValid(dmaWrValid),
        .inReady(dmaWrReady),
        .inData(dmaWrData),
        .outValid(fifoValid),
        .outReady(drainPop),
        .outData(fifoData)
    );

    // The processor port owns the memory write path; DMA drain waits a cycle.
    assign drainPop = fifoValid && !cpuMemWr && dmaState_ff == DMA_RUN && dmaToDevice;
    assign dmaRdValid = dmaState_ff == DMA_RUN && !dmaToDevice;
    assign endOfPacketMark = dmaRdValid && lastRdWord;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            dmaRdData <= DATA_RESET;
            endOfTransfer <= 1'b0;
            txCommit <= 1'b0;
            txCommitEp <= 4'h0;
        end else if (softRst_ff) begin
            dmaRdData <= DATA_RESET;
            endOfTransfer <= 1'b0;
            txCommit <= 1'b0;
            txCommitEp <= 4'h0;
        end else begin
            dmaRdData <= bufMem[dmaNxtIdx];
            endOfTransfer <= countZero && countDoneEnable;
            txCommit <= dmaToDevice && (bufEnd || extEot);
            txCommitEp <= dmaEndpoint;
        end
    end

    // ------------------------------------------------------------------
    // Endpoint status and interrupt flags
    // ------------------------------------------------------------------
    logic [15:0] statusRead;

    always_comb begin
        statusRead = '0;
        if (dataRd && cmd_ff == CMD_STAT_RD) begin
            statusRead[cmdEp_ff] = 1'b1;
        end
    end

    for (genvar e = 0; e < EP_COUNT; e++) begin : g_ep
        always_ff @(posedge clk or posedge rst) begin
            if (rst) begin
                epStatus[e] <= EP_STATUS_RESET;
                deviceIrqFlags[e] <= 1'b0;
            end else if (softRst_ff) begin
                epStatus[e] <= EP_STATUS_RESET;
                deviceIrqFlags[e] <= 1'b0;
            end else begin
                epStatus[e].full1 <= engFull1[e];
                epStatus[e].full0 <= engFull0[e];
                epStatus[e].toggle <= engToggle[e];
                epStatus[e].setupPresent <= engSetupPresent[e];
                epStatus[e].host_side_buf_select <= engCpuBuf[e];
                epStatus[e].reserved <= 1'b0;
                if (cmdTake && stallSet[e]) begin
                    epStatus[e].stall <= 1'b1;
                end else if ((cmdTake && stallClr[e]) || setupTokenIn[e]) begin
                    epStatus[e].stall <= 1'b0;
                end
                if (setupReplacedIn[e]) begin
                    epStatus[e].replaced <= 1'b1;
                end else if (statusRead[e] && !setupWriteBusy[e]) begin
                    epStatus[e].replaced <= 1'b0;
                end
                if (epEventIn[e]) begin
                    deviceIrqFlags[e] <= 1'b1;
                end else if (statusRead[e]) begin
                    deviceIrqFlags[e] <= 1'b0;
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // Read data path to the processor
    // ------------------------------------------------------------------
    logic [15:0] cpuWord_ff;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cpuWord_ff <= DATA_RESET;
        end else begin
            cpuWord_ff <= bufMem[cpuNxtIdx];
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            portDataOut <= DATA_RESET;
            portDataOeN <= 1'b1;
        end else if (softRst_ff) begin
            portDataOut <= DATA_RESET;
            portDataOeN <= 1'b1;
        end else begin
            portDataOeN <= !rdActive;
            if (cmd_ff == CMD_CNT_RD) begin
                portDataOut <= remain_ff;
            end else if (cmd_ff == CMD_STAT_RD) begin
                portDataOut <= {8'h00, epStatus[cmdEp_ff]};
            end else if (cmd_ff == CMD_BUF_RD) begin
                portDataOut <= cpuWord_ff;
            end else begin
                portDataOut <= DATA_RESET;
            end
        end
    end

endmodule

// *** ucp_pkg.sv ***
// Shared constants and types of the endpoint command port.
// Assumes a single 100 MHz clock domain and a 16-bit parallel processor port.
package ucp_pkg;

    // ------------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------------
    localparam int DATA_W = 16;
    localparam int FIFO_DEPTH = 32;
    localparam int EP_COUNT = 16;
    localparam int MEM_WORDS = 1024;
    localparam int CLK_PERIOD_NS = 10;

    // ------------------------------------------------------------------
    // Command codes and groups
    // ------------------------------------------------------------------
    localparam logic [7:0] CMD_COUNT_WR = 8'hF2;
    localparam logic [7:0] CMD_COUNT_RD = 8'hF3;
    localparam logic [7:0] CMD_SOFT_RESET = 8'hF6;
    localparam logic [3:0] GRP_BUF_WR = 4'h0;
    localparam logic [3:0] GRP_BUF_RD = 4'h1;
    localparam logic [3:0] GRP_STALL = 4'h4;
    localparam logic [3:0] GRP_STATUS = 4'h5;
    localparam logic [3:0] GRP_UNSTALL = 4'h8;
    localparam logic [3:0] EP_NONE_WR = 4'h0;
    localparam logic [3:0] EP_NONE_RD = 4'h1;

    // ------------------------------------------------------------------
    // Buffer layout and reset values
    // ------------------------------------------------------------------
    localparam logic [4:0] PTR_START = 5'h00;
    localparam logic [4:0] DMA_PTR_START = 5'h01;
    localparam logic [4:0] BUF_LAST_WORD = 5'h10;
    localparam logic [15:0] COUNT_RESET = 16'h0000;
    localparam logic [15:0] DATA_RESET = 16'h0000;
    localparam logic [15:0] BYTES_PER_WORD = 16'h0002;

    typedef struct packed {
        logic stall;
        logic full1;
        logic full0;
        logic toggle;
        logic replaced;
        logic setupPresent;
        logic host_side_buf_select;
        logic reserved;
    } ucp_ep_status_t;

    localparam ucp_ep_status_t EP_STATUS_RESET = 8'h00;

    typedef struct packed {
        logic csN;
        logic wrN;
        logic rdN;
        logic cmdSel;
        logic [15:0] data;
    } ucp_pins_t;

    localparam ucp_pins_t PINS_IDLE = 20'hE0000;

    typedef enum logic [2:0] {
        CMD_NONE,
        CMD_CNT_WR,
        CMD_CNT_RD,
        CMD_BUF_WR,
        CMD_BUF_RD,
        CMD_STAT_RD
    } ucp_cmd_t;

    typedef enum logic [1:0] {
        DMA_IDLE,
        DMA_RUN
    } ucp_dma_t;

endpackage

// *** ucp_fifo.sv ***
// Word FIFO in the DMA write path.
// Assumes both sides run on clk; a word moves when valid and ready are both high.
`timescale 1ns/100ps
module ucp_fifo
    import ucp_pkg::*;
#(
    parameter int WIDTH = DATA_W,
    parameter int DEPTH = FIFO_DEPTH
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic clr,
    input wire logic inValid,
    output logic inReady,
    input wire logic [WIDTH-1:0] inData,
    output logic outValid,
    input wire logic outReady,
    output logic [WIDTH-1:0] outData
);

    // ------------------------------------------------------------------
    // Storage and pointers
    // ------------------------------------------------------------------
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] DEPTH_CNT = (AW + 1)'(DEPTH);
    localparam logic [AW-1:0] LAST_IDX = AW'(DEPTH - 1);

    logic [WIDTH-1:0] mem_ff [0:DEPTH-1];
    logic [AW-1:0] wrPtr_ff;
    logic [AW-1:0] rdPtr_ff;
    logic [AW:0] count_ff;
    logic push;
    logic pop;

    assign inReady = (count_ff != DEPTH_CNT);
    assign outValid = (count_ff != '0);
    assign outData = mem_ff[rdPtr_ff];
    assign push = inValid && inReady;
    assign pop = outValid && outReady;

    always_ff @(posedge clk) begin
        if (push) begin
            mem_ff[wrPtr_ff] <= inData;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wrPtr_ff <= '0;
            rdPtr_ff <= '0;
            count_ff <= '0;
        end else if (clr) begin
            wrPtr_ff <= '0;
            rdPtr_ff <= '0;
            count_ff <= '0;
        end else begin
            if (push) begin
                wrPtr_ff <= (wrPtr_ff == LAST_IDX) ? '0 : wrPtr_ff + 1'b1;
            end
            if (pop) begin
                rdPtr_ff <= (rdPtr_ff == LAST_IDX) ? '0 : rdPtr_ff + 1'b1;
            end
            if (push && !pop) begin
                count_ff <= count_ff + 1'b1;
            end else if (pop && !push) begin
                count_ff <= count_ff - 1'b1;
            end
        end
    end

endmodule

// *** ucp_command_port_asserts.sv ***
// Concurrent checks on the endpoint command port.
// Assumes it is bound to ucp_command_port and sees only its ports.
`timescale 1ns/100ps
module ucp_command_port_asserts
    import ucp_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire ucp_pins_t portPins,
    input wire logic portDataOeN,
    input wire logic countDoneEnable,
    input wire logic endOfTransfer,
    input wire logic [15:0] engFull0,
    input wire logic [15:0] setupTokenIn,
    input wire logic [15:0] epEventIn,
    input wire logic [15:0] deviceIrqFlags,
    input wire ucp_ep_status_t [15:0] epStatus
);
    logic [15:0] full0Seen, resvSeen, stallSeen;
    default clocking @(posedge clk);
    endclocking
    default disable iff (rst);
    // Gathers three status fields of every endpoint into one vector each.
    always_comb begin
        for (int i = 0; i < 16; i++) begin
            full0Seen[i] = epStatus[i].full0;
            resvSeen[i] = epStatus[i].reserved;
            stallSeen[i] = epStatus[i].stall;
        end
    end
    chk_eot_enable: assert property (endOfTransfer |-> $past(countDoneEnable))
        else $error("end of transfer with count-done off");
    chk_eot_single: assert property (endOfTransfer |=> !endOfTransfer)
        else $error("end of transfer wider than one cycle");
    chk_full_copy: assert property (full0Seen == $past(engFull0))
        else $error("primary-full bits do not follow the engine");
    chk_reserved_zero: assert property (resvSeen == 16'h0000)
        else $error("reserved status bit set");
    chk_drive_on_read: assert property ($fell(portDataOeN) |-> !$past(portPins.rdN))
        else $error("data driven without a read strobe");
    chk_release_idle: assert property ($rose(portDataOeN) |-> $past(portPins.rdN))
        else $error("data released during a read strobe");
    chk_irq_set: assert property (
        (deviceIrqFlags & $past(epEventIn)) == $past(epEventIn))
        else $error("endpoint event lost its pending bit");
    chk_setup_unstall: assert property (
        |setupTokenIn |=> (stallSeen & $past(setupTokenIn)) == 16'h0000)
        else $error("set-up token left the endpoint halted");
endmodule
bind ucp_command_port ucp_command_port_asserts i_ucp_command_port_asserts (
    .clk, .rst, .portPins, .portDataOeN, .countDoneEnable, .endOfTransfer,
    .engFull0, .setupTokenIn, .epEventIn, .deviceIrqFlags, .epStatus);

// *** ucp_cpu_model.sv ***
// Processor model driving the parallel command and data port.
// Assumes the port synchronises its pins to clk.
`timescale 1ns/100ps
module ucp_cpu_model
    import ucp_pkg::*;
(
    input wire logic clk,
    input wire logic [15:0] rdData,
    output ucp_pins_t pins
);
    initial pins = PINS_IDLE;
    // Select and data stay put well past the rising strobe.
    task automatic wr(input logic sel, input logic [15:0] d);
        @(negedge clk);
        pins = '{csN: 1'h0, wrN: 1'h0, rdN: 1'h1, cmdSel: sel, data: d};
        repeat (6) @(negedge clk);
        pins.wrN = 1'h1;
        repeat (4) @(negedge clk);
        pins = '{csN: 1'h1, wrN: 1'h1, rdN: 1'h1, cmdSel: sel, data: ~d};
    endtask
    // A read lets go of the data lines, which then show a changed pattern.
    task automatic rd(output logic [15:0] q);
        @(negedge clk);
        pins = '{csN: 1'h0, wrN: 1'h1, rdN: 1'h0, cmdSel: 1'h0, data: ~pins.data};
        repeat (8) @(negedge clk);
        q = rdData;
        pins.rdN = 1'h1;
        repeat (5) @(negedge clk);
        pins.csN = 1'h1;
    endtask
endmodule

// *** usb_device_endpoint_command_port_test.sv ***
// Bench of the endpoint command port with a processor model on its pins.
// Assumes one 100 MHz clock and the checker bound to the port.
`timescale 1ns/100ps
module usb_device_endpoint_command_port_test
    import ucp_pkg::*;
;
    logic clk = '0, rst = '1, usbBusReset = '0, dmaEnable = '0, dmaToDevice = '0;
    logic countDoneEnable = '0, dmaWrValid = '0, dmaRdValid, dmaWrReady, portDataOeN;
    logic endOfPacketMark, endOfTransfer, txCommit;
    logic [3:0] dmaEndpoint = '0, txCommitEp, idx;
    logic [15:0] dmaWrData = '0, dmaRdData, portDataOut, deviceIrqFlags, q, v;
    logic [15:0] engFull0 = '0, engFull1 = '0, engToggle = '0, engSetupPresent = '0;
    logic [15:0] engCpuBuf = '0, setupTokenIn = '0, epEventIn = '0;
    logic [15:0] w [4];
    ucp_pins_t portPins;
    ucp_ep_status_t [15:0] epStatus;
    int failures = 0, samplesChecked = 0, n;
    always #5 clk = ~clk;
    ucp_command_port i_ucp_command_port (.clk, .rst, .usbBusReset, .portPins, .portDataOut,
        .portDataOeN, .dmaEnable, .dmaToDevice, .countDoneEnable, .dmaEndpoint,
        .dmaDoubleBuf(1'h0), .endOfTransferPin(1'h0), .dmaWrValid, .dmaWrReady, .dmaWrData,
        .dmaRdValid, .dmaRdReady(1'h1), .dmaRdData, .endOfPacketMark, .endOfTransfer,
        .txCommit, .txCommitEp, .engFull0, .engFull1, .engToggle, .engSetupPresent,
        .engCpuBuf, .setupTokenIn, .setupReplacedIn(16'h0000), .setupWriteBusy(16'h0000),
        .epEventIn, .deviceIrqFlags, .epStatus);
    ucp_cpu_model i_ucp_cpu_model (.clk, .rdData(portDataOut), .pins(portPins));
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        samplesChecked++;
        if (got !== exp) begin
            failures++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic rdcmd(input logic [7:0] code, output logic [15:0] d);
        i_ucp_cpu_model.wr(1'h1, {8'h00, code});
        i_ucp_cpu_model.rd(d);
    endtask
    function automatic logic [15:0] st(input logic [3:0] i);
        return {9'h000, engFull1[i], engFull0[i], engToggle[i], 1'h0, engSetupPresent[i],
            engCpuBuf[i], 1'h0};
    endfunction
    task automatic wrap_up();
        $display("comparisons %0d failures %0d", samplesChecked, failures);
        if (failures == 0 && samplesChecked > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        #200000;
        failures++;
        wrap_up();
    end
    initial begin
        void'($urandom(32'h0ECD2931));
        repeat (10) @(negedge clk);
        rst = 1'h0;
        repeat (4) @(negedge clk);
        v = 16'($urandom);
        i_ucp_cpu_model.wr(1'h1, {8'h00, CMD_COUNT_WR});
        i_ucp_cpu_model.wr(1'h0, v);
        usbBusReset = 1'h1;
        @(negedge clk);
        usbBusReset = 1'h0;
        rdcmd(CMD_COUNT_RD, q);
        chk(q, v);
        {engFull0, engFull1, engToggle, engSetupPresent, engCpuBuf} = 80'({$urandom,
            $urandom, $urandom});
        for (int k = 0; k < 3; k++) begin
            idx = (k == 0) ? 4'h2 : (k == 1) ? 4'hF : 4'(2 + $urandom_range(13));
            foreach (w[j]) w[j] = (j == 0) ? 16'h0006 : 16'($urandom);
            i_ucp_cpu_model.wr(1'h1, {12'h000, idx});
            foreach (w[j]) i_ucp_cpu_model.wr(1'h0, w[j]);
            i_ucp_cpu_model.wr(1'h1, {12'h001, idx});
            foreach (w[j]) begin
                i_ucp_cpu_model.rd(q);
                chk(q, w[j]);
            end
            epEventIn = 16'h0001 << idx;
            @(negedge clk);
            epEventIn = 16'h0000;
            chk(16'(deviceIrqFlags[idx]), 16'h0001);
            rdcmd({4'h5, idx}, q);
            chk({8'h00, q[7:0]}, st(idx));
            chk(16'(deviceIrqFlags[idx]), 16'h0000);
            i_ucp_cpu_model.wr(1'h1, {8'h00, 4'h4, idx});
            rdcmd({4'h5, idx}, q);
            chk(16'(q[7]), 16'h0001);
            setupTokenIn = 16'h0001 << idx;
            @(negedge clk);
            setupTokenIn = 16'h0000;
            rdcmd({4'h5, idx}, q);
            chk(16'(q[7]), 16'h0000);
        end
        dmaWrValid = 1'h1;
        n = 0;
        repeat (40) begin
            dmaWrData = 16'($urandom);
            n += int'(dmaWrReady);
            @(negedge clk);
        end
        @(negedge clk);
        dmaWrValid = 1'h0;
        chk(16'(n), 16'(FIFO_DEPTH));
        {dmaEndpoint, dmaToDevice, countDoneEnable} = {idx, 2'h3};
        i_ucp_cpu_model.wr(1'h1, {8'h00, CMD_COUNT_WR});
        i_ucp_cpu_model.wr(1'h0, 16'h0008);
        dmaEnable = 1'h1;
        for (n = 0; n < 200 && endOfTransfer !== 1'h1; n++) @(negedge clk);
        chk(16'(endOfTransfer), 16'h0001);
        dmaEnable = 1'h0;
        chk(16'(dmaWrReady), 16'h0001);
        rdcmd(CMD_COUNT_RD, q);
        chk(q, 16'h0008);
        dmaToDevice = 1'h0;
        dmaEnable = 1'h1;
        for (n = 0; n < 50 && endOfPacketMark !== 1'h1; n++) @(negedge clk);
        chk(16'(endOfPacketMark), 16'h0001);
        dmaEnable = 1'h0;
        {engFull0, engFull1, engToggle, engSetupPresent, engCpuBuf} = '0;
        i_ucp_cpu_model.wr(1'h1, {8'h00, CMD_SOFT_RESET});
        rdcmd(CMD_COUNT_RD, q);
        chk(q, 16'h0000);
        rdcmd({4'h5, idx}, q);
        chk({8'h00, q[7:0]}, 16'h0000);
        wrap_up();
    end
endmodule
